// >>> core/ptvi_port_ctrl.sv
// Per-port pass-all and egress tag insertion control register bank
`timescale 1ns/1ps
`include "ptvi_defs.svh"
//
// Notes on behaviour
// - One 8-bit control register per port, at 0xB0, 0xC0, 0xD0, 0xE0, 0xF0.
// - Bit 6 is a resettable read/write enable that makes the port pass all frames.
// - Bit 3 inserts the source default tag toward port 5, or port 4 from port 5.
// - Bit 2 inserts toward port 4 from ports 1-3, toward port 3 from ports 4-5.
// - Bit 1 inserts toward port 3 from ports 1-2, toward port 2 from ports 3-5.
// - No insertion happens at all unless the global insertion enable is set.
// - Bit 0 inserts toward port 2 from port 1, toward port 1 from ports 2-5.

module ptvi_port_ctrl (
  // Clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_sys_rst,
  // Register port from the serial management logic
  input  wire logic        i_wr_en,
  input  wire logic        i_rd_en,
  input  wire logic [7:0]  i_addr,
  input  wire logic [7:0]  i_wr_data,
  output logic      [7:0]  o_rd_data,
  output logic             o_rd_valid,
  // Global insertion enable from the global control bank
  input  wire logic        i_global_insert_en,
  // Controls toward the frame datapath
  output logic      [4:0]  o_pass_all,
  output logic      [24:0] o_insert_map
);

  ptvi_pkg::ptvi_state_t state_reg;
  ptvi_pkg::ptvi_state_t state_next;

  logic [24:0] map_raw;
  logic        addr_hit;
  logic [2:0]  addr_port;

  // Register image per port:
  //   bit 7    reads one, ignores writes
  //   bit 6    pass-all-frames enable
  //   bits 5-4 read zero, ignore writes
  //   bits 3-0 insert toward the other four ports, lowest egress first

  // Sizes derived from the header; decode and map are laid out for five
  localparam int NUM_PORTS = `PTVI_NUM_PORTS;
  localparam int MAP_W     = NUM_PORTS * NUM_PORTS;
  localparam int INS_W     = `PTVI_BIT_INS_HI - `PTVI_BIT_INS_LO + 1;
  localparam int ADDR_W    = `PTVI_ADDR_W;
  localparam int DATA_W    = `PTVI_DATA_W;

  localparam logic [7:0] PORT_OFS [5] = '{`PTVI_OFS_PORT1,
                                          `PTVI_OFS_PORT2,
                                          `PTVI_OFS_PORT3,
                                          `PTVI_OFS_PORT4,
                                          `PTVI_OFS_PORT5};

  // Refuse header values that the fixed decode and read image cannot serve
  generate
    if (NUM_PORTS != 5) begin : g_chk_ports
      $error("control bank needs exactly five ports");
    end
    if (INS_W != NUM_PORTS - 1) begin : g_chk_ins
      $error("control bank needs one insert bit per other port");
    end
    if (MAP_W != 25) begin : g_chk_map
      $error("map width must match the insert map output");
    end
    if (ADDR_W != 8 || DATA_W != 8) begin : g_chk_bus
      $error("register port is eight bits wide");
    end
    if (`PTVI_BIT_PASS_ALL <= `PTVI_BIT_INS_HI) begin : g_chk_fields
      $error("pass-all bit must sit above the insert field");
    end
    if (`PTVI_BIT_RSVD_ONE != DATA_W - 1) begin : g_chk_top
      $error("reserved one must be the top data bit");
    end
    if (`PTVI_BIT_INS_LO != 0) begin : g_chk_lo
      $error("insert field must start at bit zero");
    end
    if (`PTVI_RST_PASS_ALL != 1'h0 || `PTVI_RST_INSERT != 4'h0) begin : g_chk_rst
      $error("control fields reset to zero");
    end
  endgenerate

  // Egress reached by each insert bit, per source port:
  //   source 1: bit0->2 bit1->3 bit2->4 bit3->5
  //   source 2: bit0->1 bit1->3 bit2->4 bit3->5
  //   source 3: bit0->1 bit1->2 bit2->4 bit3->5
  //   source 4: bit0->1 bit1->2 bit2->3 bit3->5
  //   source 5: bit0->1 bit1->2 bit2->3 bit3->4

  // Read image and access selects of every port
  logic [7:0] rd_image [5];
  logic [4:0] wr_sel;
  logic [4:0] rd_sel;
  logic [7:0] rd_pick;

  genvar gp;
  generate
    for (gp = 0; gp < `PTVI_NUM_PORTS; gp++) begin : g_port
      if ((PORT_OFS[gp] & `PTVI_OFS_LOW_MASK) != 8'h00) begin : g_chk_ofs
        $error("port offsets must have a zero low nibble");
      end
      if (PORT_OFS[gp][7:4] != 4'(`PTVI_OFS_BASE_HI + gp)) begin : g_chk_step
        $error("port offsets must step by sixteen from the base");
      end
      // Reserved positions are constants, never storage
      assign rd_image[gp] = {`PTVI_RSVD_ONE_VAL,
                             state_reg.port[gp].pass_all,
                             `PTVI_RSVD_MID_VAL,
                             state_reg.port[gp].insert};
      assign wr_sel[gp] = i_wr_en && addr_hit &&
                          (addr_port == 3'(gp));
      assign rd_sel[gp] = i_rd_en && addr_hit &&
                          (addr_port == 3'(gp));
    end
  endgenerate

  // One-hot select; an unmapped read returns the unmapped value
  always_comb begin
    rd_pick = `PTVI_UNMAPPED_VAL;
    for (int p = 0; p < `PTVI_NUM_PORTS; p++) begin
      if (rd_sel[p]) begin
        rd_pick = rd_image[p];
      end
    end
  end

  // Source-major map: bit src*5+egress; bit k skips the source itself
  genvar gs;
  genvar ge;
  generate
    for (gs = 0; gs < `PTVI_NUM_PORTS; gs++) begin : g_src
      for (ge = 0; ge < `PTVI_NUM_PORTS; ge++) begin : g_egr
        if (ge == gs) begin : g_self
          assign map_raw[gs*5+ge] = 1'b0;
        end else if (ge < gs) begin : g_below
          assign map_raw[gs*5+ge] = state_reg.port[gs].insert[ge];
        end else begin : g_above
          assign map_raw[gs*5+ge] = state_reg.port[gs].insert[ge-1];
        end
      end
    end
  endgenerate

  // Decode 0xB0..0xF0 only; any other low nibble is unmapped
  always_comb begin
    addr_hit  = 1'b0;
    addr_port = 3'h0;
    unique case (i_addr)
      `PTVI_OFS_PORT1: begin addr_hit = 1'b1; addr_port = 3'h0; end
      `PTVI_OFS_PORT2: begin addr_hit = 1'b1; addr_port = 3'h1; end
      `PTVI_OFS_PORT3: begin addr_hit = 1'b1; addr_port = 3'h2; end
      `PTVI_OFS_PORT4: begin addr_hit = 1'b1; addr_port = 3'h3; end
      `PTVI_OFS_PORT5: begin addr_hit = 1'b1; addr_port = 3'h4; end
      default: begin addr_hit = 1'b0; addr_port = 3'h0; end
    endcase
  end

  always_comb begin
    state_next          = state_reg;
    state_next.rd_valid = 1'b0;
    for (int p = 0; p < `PTVI_NUM_PORTS; p++) begin
      if (wr_sel[p]) begin
        // Reserved positions of the write data are dropped
        state_next.port[p].pass_all =
          i_wr_data[`PTVI_BIT_PASS_ALL];
        state_next.port[p].insert =
          i_wr_data[`PTVI_BIT_INS_HI:`PTVI_BIT_INS_LO];
      end
    end
    if (i_rd_en) begin
      state_next.rd_valid = 1'b1;
      // Image is taken before the write, so a same-edge write reads old
      state_next.rd_data  = rd_pick;
    end
    for (int p = 0; p < `PTVI_NUM_PORTS; p++) begin
      state_next.pass_all[p] = state_reg.port[p].pass_all;
    end
    // Gate registered so the datapath sees a glitch-free map
    state_next.insert_map = i_global_insert_en ? map_raw : 25'h0000000;
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      for (int p = 0; p < `PTVI_NUM_PORTS; p++) begin
        state_reg.port[p].pass_all <= `PTVI_RST_PASS_ALL;
        state_reg.port[p].insert   <= `PTVI_RST_INSERT;
      end
      state_reg.insert_map <= 25'h0000000;
      state_reg.pass_all   <= 5'h00;
      state_reg.rd_data    <= 8'h00;
      state_reg.rd_valid   <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_rd_data    = state_reg.rd_data;
  assign o_rd_valid   = state_reg.rd_valid;
  assign o_pass_all   = state_reg.pass_all;
  assign o_insert_map = state_reg.insert_map;

endmodule : ptvi_port_ctrl

// >>> common/ptvi_defs.svh
// Offsets, field positions, reset values of the per-port insertion control
`ifndef PTVI_DEFS_SVH
`define PTVI_DEFS_SVH

`define PTVI_NUM_PORTS      5
`define PTVI_ADDR_W         8
`define PTVI_DATA_W         8

`define PTVI_OFS_PORT1      8'hB0
`define PTVI_OFS_PORT2      8'hC0
`define PTVI_OFS_PORT3      8'hD0
`define PTVI_OFS_PORT4      8'hE0
`define PTVI_OFS_PORT5      8'hF0
`define PTVI_OFS_LOW_MASK   8'h0F
`define PTVI_OFS_BASE_HI    4'hB

`define PTVI_BIT_RSVD_ONE   7
`define PTVI_BIT_PASS_ALL   6
`define PTVI_BIT_INS_HI     3
`define PTVI_BIT_INS_LO     0

`define PTVI_RST_PASS_ALL   1'h0
`define PTVI_RST_INSERT     4'h0
`define PTVI_RSVD_ONE_VAL   1'h1
`define PTVI_RSVD_MID_VAL   2'h0
`define PTVI_UNMAPPED_VAL   8'h00

`endif

// >>> common/ptvi_pkg.sv
// Types of the per-port insertion control register bank
package ptvi_pkg;

  typedef struct packed {
    logic       pass_all;
    logic [3:0] insert;
  } ptvi_port_t;

  typedef struct packed {
    ptvi_port_t [4:0]  port;
    logic       [24:0] insert_map;
    logic       [4:0]  pass_all;
    logic       [7:0]  rd_data;
    logic              rd_valid;
  } ptvi_state_t;

endpackage : ptvi_pkg

// >>> testbench/ptvi_monitor.sv
// Port-level checker of the insertion control bank
`timescale 1ns/1ps
module ptvi_monitor (
  input logic        i_clock,
  input logic        i_sys_rst,
  input logic        i_wr_en,
  input logic        i_rd_en,
  input logic [7:0]  i_addr,
  input logic [7:0]  i_wr_data,
  input logic [7:0]  o_rd_data,
  input logic        o_rd_valid,
  input logic        i_global_insert_en,
  input logic [4:0]  o_pass_all,
  input logic [24:0] o_insert_map
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);
  wire hit = i_addr[3:0] == 4'h0 && i_addr[7:4] >= 4'hB;
  wire w1 = i_wr_en && i_addr == 8'hB0;
  wire w5 = i_wr_en && i_addr == 8'hF0;
  a_rd_mapped: assert property (i_rd_en && hit |=> o_rd_valid && o_rd_data[7])
    else $error("mapped read");
  a_rd_unmapped: assert property (i_rd_en && !hit |=> o_rd_data == 8'h00)
    else $error("unmapped read");
  a_rd_quiet: assert property (!i_rd_en |=> !o_rd_valid)
    else $error("stray valid");
  a_rsvd_zero: assert property (o_rd_valid |-> o_rd_data[5:4] == 2'h0)
    else $error("reserved bits");
  a_pass_all: assert property (w1 |=> ##1 o_pass_all[0] == $past(i_wr_data[6], 2))
    else $error("pass all");
  a_map_first: assert property (w1 ##1 i_global_insert_en |=>
    o_insert_map[4:0] == {$past(i_wr_data[3:0], 2), 1'h0})
    else $error("port 1 map");
  a_map_last: assert property (w5 ##1 i_global_insert_en |=>
    o_insert_map[24:20] == {1'h0, $past(i_wr_data[3:0], 2)})
    else $error("port 5 map");
  a_global_off: assert property (!i_global_insert_en |=> o_insert_map == 25'h0)
    else $error("global off");
  c_pass: cover property (w1 ##2 o_pass_all[0]);
  c_unmapped: cover property (i_rd_en && !hit);
  c_off: cover property ($fell(i_global_insert_en));
endmodule : ptvi_monitor
bind ptvi_port_ctrl ptvi_monitor mon (.*);

// >>> testbench/ptvi_host_model.sv
// Host model issuing strobe accesses
`timescale 1ns/1ps
module ptvi_host_model (
  input  logic       i_clock,
  output logic       o_wr_en = 1'h0,
  output logic       o_rd_en = 1'h0,
  output logic [7:0] o_addr = 8'h00,
  output logic [7:0] o_wr_data = 8'h00
);
  // Released address and data lines show inverted values; both enables drop to zero
  task automatic acc(input logic w, input logic [7:0] a, dv);
    @(posedge i_clock) #1 {o_wr_en, o_rd_en, o_addr, o_wr_data} = {w, !w, a, dv};
    @(posedge i_clock) #1 {o_wr_en, o_rd_en, o_addr, o_wr_data} = {2'h0, ~a, ~dv};
  endtask : acc
endmodule : ptvi_host_model

// >>> testbench/test_port_egress_vid_insert_ctrl.sv
// Self-checking bench of the insertion control bank
`timescale 1ns/1ps
module test_port_egress_vid_insert_ctrl;
  logic i_clock = 1'h0, i_sys_rst = 1'h1, glob = 1'h0, wr, rd, rv;
  logic [7:0]  a, d, rdat;
  logic [4:0]  pa;
  logic [24:0] map, em;
  int failures = 0, total_checks = 0;
  always #5 i_clock = ~i_clock;
  ptvi_host_model host (.i_clock(i_clock), .o_wr_en(wr), .o_rd_en(rd),
    .o_addr(a), .o_wr_data(d));
  ptvi_port_ctrl uut (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_wr_en(wr),
    .i_rd_en(rd), .i_addr(a), .i_wr_data(d), .o_rd_data(rdat), .o_rd_valid(rv),
    .i_global_insert_en(glob), .o_pass_all(pa), .o_insert_map(map));
  task automatic chk(input logic [24:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: %h not %h", $time, got, exp);
    end
  endtask : chk
  task automatic rdc(input logic [7:0] ad, exp);
    host.acc(1'h0, ad, 8'h00);
    chk(rv, 1'h1);
    chk(rdat, exp);
  endtask : rdc
  task automatic report_and_stop;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (3) @(posedge i_clock);
    #1 i_sys_rst = 1'h0;
    for (int p = 0; p < 5; p++) rdc(8'hB0 + 8'(p * 16), 8'h80);
    rdc(8'hB1, 8'h00);
    $display("reset test end");
    glob = 1'h1;
    // Reserved bits written high on purpose
    for (int k = 0; k < 4; k++) begin
      em = '0;
      for (int p = 0; p < 5; p++) begin
        host.acc(1'h1, 8'hB0 + 8'(p * 16), 8'hB0 | 8'(1 << k));
        em[p * 5 + (k < p ? k : k + 1)] = 1'h1;
      end
      @(posedge i_clock) #1 chk(map, em);
    end
    rdc(8'hF0, 8'h88);
    glob = 1'h0;
    @(posedge i_clock) #1 chk(map, 25'h0);
    glob = 1'h1;
    $display("insert test end");
    host.acc(1'h1, 8'hC0, 8'h40);
    host.acc(1'h1, 8'hC8, 8'hFF);
    rdc(8'hC0, 8'hC0);
    chk(pa, 5'h02);
    $display("pass all test end");
    report_and_stop();
  end
endmodule : test_port_egress_vid_insert_ctrl
